/* hdl/timer16_params.svh */
// Constants of the 16-bit timer/counter: offsets, fields, reset values.
// Included by the package, count16, timer16_top and the test bench; definitions only.
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH

`define OFS_CONTROL 8'h10
`define OFS_COUNT_LOW 8'h14
`define OFS_COUNT_HIGH 8'h18
`define OFS_IRQ_STATUS 8'h1c
`define OFS_IRQ_MASK 8'h20

`define BIT_RUN_ENABLE 0
`define BIT_CLOCK_SOURCE_SELECT 1
`define BIT_SYNC_DISABLE 2
`define BIT_OSCILLATOR_ENABLE 3
`define BIT_IRQ_OVERFLOW 0

`define CONTROL_WMASK 8'h3f
`define CONTROL_RESET 8'h00
`define IRQ_WMASK 8'h01
`define COUNT_ONES 16'hffff
`define COUNT_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define COUNT_STEP 16'h0001

`endif

/* hdl/timer16_pkg.sv */
// Types shared by the 16-bit timer/counter design.
// Assumes the params header sits on the include path.
`include "timer16_params.svh"

package timer16_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_SYNC_COUNTER,
    MODE_ASYNC_COUNTER
  } count_mode_t;

  typedef struct packed {
    logic [7:0] adr;
    logic we;
    logic [7:0] dat;
    logic sel;
  } bus_req_t;

  typedef struct packed {
    logic osc_in_oe_n;
    logic osc_out_oe_n;
  } pin_dir_t;

endpackage

/* hdl/edge_sync.sv */
// Rising-edge detector for the external count clock.
// Two-stage synchroniser, or a single sampling stage when bypassed.
`timescale 1ns/10ps
`default_nettype none

module edge_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ext_clk_i,
  input wire logic sync_en_i,
  output logic rise_o
);

  logic meta_q;
  logic sync_q;
  logic direct_q;
  logic last_q;
  logic level;

  // Synchroniser and direct sample
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      direct_q <= 1'b0;
    end else begin
      meta_q <= ext_clk_i;
      sync_q <= meta_q;
      direct_q <= ext_clk_i;
    end
  end

  assign level = sync_en_i ? sync_q : direct_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      last_q <= 1'b0;
    end else begin
      last_q <= level;
    end
  end

  // Rising edges only
  assign rise_o = level & ~last_q;

endmodule // edge_sync

`default_nettype wire

/* hdl/count16.sv */
// The 16-bit count split as two byte registers with wrap detection.
// Assumes one-cycle strobes from the register block.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"

module count16
  import timer16_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic clear_i,
  input wire logic wr_low_i,
  input wire logic wr_high_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] low_o,
  output logic [7:0] high_o,
  output logic wrap_o
);

  logic [7:0] low_q;
  logic [7:0] high_q;
  logic [15:0] next;

  assign next = {high_q, low_q} + `COUNT_STEP;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || clear_i) begin
      low_q <= `BYTE_ZERO;
      high_q <= `BYTE_ZERO;
    end else if (wr_low_i || wr_high_i) begin
      if (wr_low_i) begin
        low_q <= wdata_i;
      end
      if (wr_high_i) begin
        high_q <= wdata_i;
      end
    end else if (step_i) begin
      low_q <= next[7:0];
      high_q <= next[15:8];
    end
  end

  // Wrap from all ones to zero
  assign wrap_o = rst_n_i && !clear_i && !wr_low_i && !wr_high_i && step_i
    && ({high_q, low_q} == `COUNT_ONES);
  assign low_o = low_q;
  assign high_o = high_q;

endmodule // count16

`default_nettype wire

/* hdl/timer16_top.sv */
// Top of the 16-bit timer/counter with a classic Wishbone slave.
// Assumes mclk_i is the instruction-cycle clock and pins are synchronous.
//
// Summary of operation
// - The count is 16 bits held as a low-byte and a high-byte register.
// - Software reads and writes both count byte registers.
// - Overflow is flagged when the count wraps from ffff to 0000.
// - A capture/compare trigger input clears the whole count.
// - Counting happens only while run_enable (control bit 0) is set.
// - Control bit 1, clock_source_select, picks timer or counter mode.
// - Timer mode adds one on every instruction cycle.
// - Counter mode adds one on each rising external edge, never falling.
// - oscillator_enable forces both oscillator pins to inputs.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"

module timer16_top
  import timer16_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic capture_compare_reset_i,
  input wire logic oscillator_output_clock_pin_i,
  input wire logic [2:1] port_direction_bits_i,
  output logic oscillator_input_pin_oe_n_o,
  output logic oscillator_output_clock_pin_oe_n_o,
  output logic irq_o
);

  bus_req_t req;
  pin_dir_t pin_dir;
  count_mode_t mode;
  logic [7:0] control_q;
  logic [7:0] irq_status_q;
  logic [7:0] irq_mask_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic err_q;
  logic access;
  logic hit;
  logic wr;
  logic wr_low;
  logic wr_high;
  logic ext_rise;
  logic step;
  logic wrap;
  logic [7:0] count_low;
  logic [7:0] count_high;

  function automatic logic is_mapped(input logic [7:0] adr);
    is_mapped = (adr == `OFS_CONTROL) || (adr == `OFS_COUNT_LOW) ||
      (adr == `OFS_COUNT_HIGH) || (adr == `OFS_IRQ_STATUS) ||
      (adr == `OFS_IRQ_MASK);
  endfunction

  assign req = '{adr: wb_adr_i, we: wb_we_i, dat: wb_dat_i[7:0], sel: wb_sel_i[0]};
  assign access = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  assign hit = access && is_mapped(req.adr);
  assign wr = hit && req.we && req.sel;
  assign wr_low = wr && (req.adr == `OFS_COUNT_LOW);
  assign wr_high = wr && (req.adr == `OFS_COUNT_HIGH);

  // Mode decode
  always_comb begin
    if (!control_q[`BIT_CLOCK_SOURCE_SELECT]) begin
      mode = MODE_TIMER;
    end else if (control_q[`BIT_SYNC_DISABLE]) begin
      mode = MODE_ASYNC_COUNTER;
    end else begin
      mode = MODE_SYNC_COUNTER;
    end
  end

  edge_sync u_edge_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ext_clk_i(oscillator_output_clock_pin_i),
    .sync_en_i(mode == MODE_SYNC_COUNTER),
    .rise_o(ext_rise)
  );

  // Count step selection
  always_comb begin
    case (mode)
      MODE_TIMER: step = 1'b1;
      MODE_SYNC_COUNTER: step = ext_rise;
      MODE_ASYNC_COUNTER: step = ext_rise;
      default: step = 1'b0;
    endcase
    step = step && control_q[`BIT_RUN_ENABLE];
  end

  count16 u_count16 (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .step_i(step),
    .clear_i(capture_compare_reset_i),
    .wr_low_i(wr_low),
    .wr_high_i(wr_high),
    .wdata_i(req.dat),
    .low_o(count_low),
    .high_o(count_high),
    .wrap_o(wrap)
  );

  // Control register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      control_q <= `CONTROL_RESET;
    end else if (wr && req.adr == `OFS_CONTROL) begin
      control_q <= req.dat & `CONTROL_WMASK;
    end
  end

  // Sticky overflow flag, set wins over clear
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_status_q <= `BYTE_ZERO;
    end else begin
      if (wr && req.adr == `OFS_IRQ_STATUS) begin
        irq_status_q <= irq_status_q & ~(req.dat & `IRQ_WMASK);
      end
      if (wrap) begin
        irq_status_q[`BIT_IRQ_OVERFLOW] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= `BYTE_ZERO;
    end else if (wr && req.adr == `OFS_IRQ_MASK) begin
      irq_mask_q <= req.dat & `IRQ_WMASK;
    end
  end

  assign irq_o = |(irq_status_q & irq_mask_q);

  // Bus answer: ack one cycle after request, err on unmapped address
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= hit;
      err_q <= access && !hit;
      if (hit && !req.we) begin
        case (req.adr)
          `OFS_CONTROL: rdata_q <= {24'h00_0000, control_q};
          `OFS_COUNT_LOW: rdata_q <= {24'h00_0000, count_low};
          `OFS_COUNT_HIGH: rdata_q <= {24'h00_0000, count_high};
          `OFS_IRQ_STATUS: rdata_q <= {24'h00_0000, irq_status_q};
          `OFS_IRQ_MASK: rdata_q <= {24'h00_0000, irq_mask_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  // Pin direction override
  assign pin_dir.osc_in_oe_n = control_q[`BIT_OSCILLATOR_ENABLE] | port_direction_bits_i[2];
  assign pin_dir.osc_out_oe_n = control_q[`BIT_OSCILLATOR_ENABLE] | port_direction_bits_i[1];
  assign oscillator_input_pin_oe_n_o = pin_dir.osc_in_oe_n;
  assign oscillator_output_clock_pin_oe_n_o = pin_dir.osc_out_oe_n;

endmodule // timer16_top

`default_nettype wire

/* verif/timer16_props.sv */
// Checker of bus answers, irq and pin directions of the timer.
// Bound into timer16_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module timer16_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic irq_o,
  input wire logic [2:1] port_direction_bits_i,
  input wire logic oscillator_input_pin_oe_n_o,
  input wire logic oscillator_output_clock_pin_oe_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no single answer");
  property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_err; wb_err_o |=> !wb_err_o; endproperty
  a_err: assert property (p_err) else $error("err too long");
  property p_idle; !wb_cyc_i |=> !wb_ack_o && !wb_err_o; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_hi; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_keep; irq_o && !wb_we_i |=> irq_o; endproperty
  a_keep: assert property (p_keep) else $error("irq dropped");
  property p_oin; !oscillator_input_pin_oe_n_o |-> !port_direction_bits_i[2]; endproperty
  a_oin: assert property (p_oin) else $error("input pin driven");
  property p_oout; !oscillator_output_clock_pin_oe_n_o |-> !port_direction_bits_i[1];
  endproperty
  a_oout: assert property (p_oout) else $error("clock pin driven");
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (wb_err_o);
  c_osc: cover property (oscillator_input_pin_oe_n_o && !port_direction_bits_i[2]);
endmodule // timer16_props
bind timer16_top timer16_props u_props (.*);
`default_nettype wire

/* verif/ext_clk_model.sv */
// External count clock: a burst of rising edges on request.
// Idles low between bursts; one edge every 8 mclk cycles.
`timescale 1ns/10ps
`default_nettype none
module ext_clk_model (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [3:0] n_i,
  output logic clk_o = 1'b0
);
  logic [4:0] left_q = 5'h00;
  logic [1:0] div_q = 2'h0;
  always_ff @(posedge mclk_i) begin
    div_q <= div_q + 2'h1;
    if (go_i) begin
      left_q <= {n_i, 1'b0};
    end else if (left_q != 5'h00 && div_q == 2'h0) begin
      left_q <= left_q - 5'h01;
      clk_o <= ~clk_o;
    end
  end
endmodule // ext_clk_model
`default_nettype wire

/* verif/sixteen_bit_timer_counter_test.sv */
// Self-checking bench of the 16-bit timer/counter.
// Drives Wishbone, capture clear and the count pin model.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_params.svh"
module sixteen_bit_timer_counter_test;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic capture_compare_unit = 1'b0, go = 1'b0, e, ack, err, oe_in, oe_out, irq, pin;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic [3:0] n_edges = 4'h0;
  logic [2:1] dir = 2'h3;
  logic [15:0] v;
  int n_mismatch = 0, checked = 0, cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  timer16_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .capture_compare_reset_i(capture_compare_unit),
    .oscillator_output_clock_pin_i(pin), .port_direction_bits_i(dir),
    .oscillator_input_pin_oe_n_o(oe_in), .oscillator_output_clock_pin_oe_n_o(oe_out),
    .irq_o(irq));
  ext_clk_model u_src (.mclk_i(mclk_i), .go_i(go), .n_i(n_edges), .clk_o(pin));
  function automatic logic [1:0] oe_exp(input logic osc, input logic [2:1] d);
    return {osc | d[2], osc | d[1]};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge mclk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d};
    do @(posedge mclk_i); while (!(ack || err));
    q = dat_o; e = err;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, q, exp);
  endtask
  task automatic burst(input logic [3:0] n);
    @(posedge mclk_i) begin go <= 1'b1; n_edges <= n; end
    @(posedge mclk_i) go <= 1'b0;
    repeat (70) @(posedge mclk_i);
  endtask
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin n_mismatch++; test_done(); end
  end
  initial begin
    void'($urandom(3858));
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) rd(8'h10 + 8'(4 * i), 32'h0, "reset");
    bus(1'b0, 8'h04, 8'h00);
    chk("err", 32'(e), 32'h1);
    repeat (4) begin
      v = 16'($urandom);
      bus(1'b1, `OFS_COUNT_LOW, v[7:0]);
      bus(1'b1, `OFS_COUNT_HIGH, v[15:8]);
      rd(`OFS_COUNT_LOW, 32'(v[7:0]), "low");
      rd(`OFS_COUNT_HIGH, 32'(v[15:8]), "high");
    end
    sel <= 4'h0;
    bus(1'b1, `OFS_COUNT_LOW, ~v[7:0]);
    sel <= 4'h1;
    rd(`OFS_COUNT_LOW, 32'(v[7:0]), "sel off");
    @(posedge mclk_i) capture_compare_unit <= 1'b1;
    @(posedge mclk_i) capture_compare_unit <= 1'b0;
    rd(`OFS_COUNT_LOW, 32'h0, "clr low");
    rd(`OFS_COUNT_HIGH, 32'h0, "clr high");
    $display("registers done");
    bus(1'b1, `OFS_COUNT_LOW, 8'hfe);
    bus(1'b1, `OFS_COUNT_HIGH, 8'hff);
    bus(1'b1, `OFS_IRQ_MASK, 8'h01);
    bus(1'b1, `OFS_CONTROL, 8'h01);
    repeat (8) @(negedge mclk_i);
    chk("irq", 32'(irq), 32'h1);
    rd(`OFS_IRQ_STATUS, 32'h1, "status");
    bus(1'b1, `OFS_CONTROL, 8'h00);
    rd(`OFS_COUNT_HIGH, 32'h0, "stopped");
    bus(1'b0, `OFS_COUNT_LOW, 8'h00);
    v = q[15:0];
    repeat (5) @(negedge mclk_i);
    rd(`OFS_COUNT_LOW, 32'(v), "held");
    bus(1'b1, `OFS_IRQ_MASK, 8'h00);
    @(negedge mclk_i) chk("masked", 32'(irq), 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 8'h01);
    bus(1'b1, `OFS_IRQ_STATUS, 8'h01);
    @(negedge mclk_i) chk("cleared", 32'(irq), 32'h0);
    $display("overflow done");
    bus(1'b1, `OFS_COUNT_LOW, 8'h00);
    bus(1'b1, `OFS_COUNT_HIGH, 8'h00);
    bus(1'b1, `OFS_CONTROL, 8'h01);
    bus(1'b1, `OFS_CONTROL, 8'h00);
    rd(`OFS_COUNT_LOW, 32'h3, "timer steps");
    bus(1'b1, `OFS_COUNT_LOW, 8'h00);
    bus(1'b1, `OFS_CONTROL, 8'h03);
    burst(4'h5);
    rd(`OFS_COUNT_LOW, 32'h5, "sync");
    bus(1'b1, `OFS_CONTROL, 8'h07);
    burst(4'h3);
    rd(`OFS_COUNT_LOW, 32'h8, "async");
    $display("counter done");
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk_i) dir <= 2'($urandom);
      bus(1'b1, `OFS_CONTROL, {4'h0, k[0], 3'h0});
      @(negedge mclk_i) chk("oe", 32'({oe_in, oe_out}), 32'(oe_exp(k[0], dir)));
    end
    $display("pins done");
    test_done();
  end
endmodule // sixteen_bit_timer_counter_test
`default_nettype wire
